/* File: core/ctr_clock_tree.sv */
/*
  Clock tree root selection: path muxes, FREQUENCY_LOCKED_LOOP loop, root muxes with predividers,
  low-frequency, pump, timer and derived core and peripheral clocks, APB registers.
  Assumes oscillator levels arrive asynchronously and are far slower than clk_sys.
*/
// Added by the designer: the address map and the APB slave port.
`include "ctr_clock_tree_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// Integer divider on the rising edges of a sampled clock level
// ==========================================================================
module ctr_div (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Source and control
  input wire logic src,
  input wire logic [7:0] div,
  input wire logic en,
  // Divided level
  output logic out_q
);
  logic prev_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire rise = src & ~prev_q;
  wire wrap = (cnt_q >= div);

  assign cnt_d = rise ? (wrap ? 8'h00 : cnt_q + 8'h01) : cnt_q;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      prev_q <= 1'b0;
      cnt_q <= 8'h00;
      out_q <= 1'b0;
    end
    else
    begin
      prev_q <= src;
      cnt_q <= en ? cnt_d : 8'h00;
      if (!en)
        out_q <= 1'b0;
      else if (div == 8'h00)
        out_q <= src;
      else
        out_q <= (cnt_d <= {1'b0, div[7:1]});
    end
  end
endmodule // ctr_div

// ==========================================================================
// Top level
// ==========================================================================
module ctr_clock_tree (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire ctr_pkg::ctr_apb_req_t apb_req,
  output ctr_pkg::ctr_apb_rsp_t apb_rsp_q,
  // Oscillator and source inputs
  input wire logic internal_main_osc,
  input wire logic external_clock_in,
  input wire logic external_crystal_osc,
  input wire logic alternate_high_freq_source,
  input wire logic internal_low_osc,
  input wire logic watch_crystal_osc,
  input wire logic precision_low_osc,
  input wire logic [1:0] interconnect_out,
  input wire logic controlled_osc,
  input wire logic pll_clk,
  input wire logic pump_alt_clk,
  // Loop control to the oscillator
  output logic [8:0] controlled_osc_freq_q,
  output logic fll_lock_q,
  // Root clocks and their interconnect copies
  output logic [4:0] high_freq_root_clock,
  output logic [4:0] interconnect_root_clock,
  // Derived clocks
  output logic low_freq_clock_q,
  output logic pump_clock_q,
  output logic timer_clock_q,
  output logic core_clock_q,
  output logic peripheral_source_clock_q,
  output logic aux_core_clock_q,
  output logic group_clock_q
);
  import ctr_pkg::*;

  // ========================================================================
  // Input synchronisers
  // ========================================================================
  logic [`CTR_NSRC-1:0] src_m_q;
  logic [`CTR_NSRC-1:0] src_s_q;
  logic [`CTR_NSRC-1:0] src_p_q;
  wire [`CTR_NSRC-1:0] src_raw = {pump_alt_clk, pll_clk, controlled_osc, interconnect_out,
    precision_low_osc, watch_crystal_osc, internal_low_osc, alternate_high_freq_source,
    external_crystal_osc, external_clock_in, internal_main_osc};

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      src_m_q <= '0;
      src_s_q <= '0;
      src_p_q <= '0;
    end
    else
    begin
      src_m_q <= src_raw;
      src_s_q <= src_m_q;
      src_p_q <= src_s_q;
    end
  end

  // ========================================================================
  // Registers
  // ========================================================================
  logic [31:0] path_sel_q;
  logic [31:0] ic_sel_q;
  logic [31:0] misc_q;
  logic [31:0] div_q;
  logic [31:0] root_q [5];
  logic [31:0] fll0_q;
  logic [31:0] fll1_q;
  logic [31:0] status_w;
  logic [31:0] rdata_w;
  logic hit_w;

  wire setup_w = apb_req.psel & ~apb_req.penable;
  wire wr_w = apb_req.psel & apb_req.penable & apb_rsp_q.pready & apb_req.pwrite;
  wire [11:0] addr_w = apb_req.paddr;
  wire root_hit_w = (addr_w >= `CTR_OFS_ROOT0) && (addr_w < `CTR_OFS_FLL0)
    && (addr_w[1:0] == 2'b00);
  wire [2:0] root_idx_w = 3'(addr_w[11:2] - 10'(`CTR_OFS_ROOT0 >> 2));

  assign hit_w = root_hit_w || (addr_w == `CTR_OFS_PATH_SEL) || (addr_w == `CTR_OFS_IC_SEL)
    || (addr_w == `CTR_OFS_MISC) || (addr_w == `CTR_OFS_DIV) || (addr_w == `CTR_OFS_FLL0)
    || (addr_w == `CTR_OFS_FLL1) || (addr_w == `CTR_OFS_STATUS);

  assign rdata_w =
    (addr_w == `CTR_OFS_PATH_SEL) ? path_sel_q :
    (addr_w == `CTR_OFS_IC_SEL) ? ic_sel_q :
    (addr_w == `CTR_OFS_MISC) ? misc_q :
    (addr_w == `CTR_OFS_DIV) ? div_q :
    root_hit_w ? root_q[root_idx_w] :
    (addr_w == `CTR_OFS_FLL0) ? fll0_q :
    (addr_w == `CTR_OFS_FLL1) ? fll1_q :
    (addr_w == `CTR_OFS_STATUS) ? status_w : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      apb_rsp_q <= '0;
    else
    begin
      apb_rsp_q.pready <= setup_w;
      apb_rsp_q.pslverr <= setup_w & ~hit_w;
      apb_rsp_q.prdata <= (setup_w & ~apb_req.pwrite) ? rdata_w : 32'h0000_0000;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      path_sel_q <= 32'h0000_0000;
      ic_sel_q <= 32'h0000_0000;
      misc_q <= `CTR_MISC_RST;
      div_q <= 32'h0000_0000;
      fll0_q <= `CTR_FLL0_RST;
      fll1_q <= `CTR_FLL1_RST;
    end
    else if (wr_w)
    begin
      if (addr_w == `CTR_OFS_PATH_SEL)
        path_sel_q <= {17'h00000, apb_req.pwdata[14:0]};
      else if (addr_w == `CTR_OFS_IC_SEL)
        ic_sel_q <= {7'h00, apb_req.pwdata[24:0]};
      else if (addr_w == `CTR_OFS_MISC)
        misc_q <= {17'h00000, apb_req.pwdata[14:0]};
      else if (addr_w == `CTR_OFS_DIV)
        div_q <= apb_req.pwdata;
      else if (addr_w == `CTR_OFS_FLL0)
        fll0_q <= apb_req.pwdata;
      else if (addr_w == `CTR_OFS_FLL1)
        fll1_q <= {23'h000000, apb_req.pwdata[8:0]};
    end
  end

  // ========================================================================
  // Path source and interconnect muxes
  // ========================================================================
  logic [4:0] ic_mux_w;
  logic [4:0] path_src_w;
  logic [4:0] path_q;

  for (genvar i = 0; i < 5; i++)
  begin : g_path
    wire [2:0] psel_w = path_sel_q[3*i+2:3*i];
    wire [4:0] isel_w = ic_sel_q[5*i+4:5*i];
    assign ic_mux_w[i] =
      (isel_w == 5'h00) ? src_s_q[`CTR_SRC_IC0] :
      (isel_w == 5'h01) ? src_s_q[`CTR_SRC_IC0+1] :
      (isel_w == 5'h10) ? src_s_q[`CTR_SRC_ILO] :
      (isel_w == 5'h11) ? src_s_q[`CTR_SRC_WCO] :
      (isel_w == 5'h13) ? src_s_q[`CTR_SRC_PRECISION_LOW_OSC] : 1'b0;
    assign path_src_w[i] =
      (psel_w <= 3'h3) ? src_s_q[psel_w] :
      (psel_w == 3'h4) ? ic_mux_w[i] : 1'b0;
  end

  // Path 0 carries the FREQUENCY_LOCKED_LOOP, path 1 the PLL, others pass straight through
  wire fll_byp_w = misc_q[`CTR_MISC_FLL_BYP] | ~fll1_q[8];
  wire [4:0] path_d = {path_src_w[4:2],
    misc_q[`CTR_MISC_PLL_BYP] ? path_src_w[1] : src_s_q[`CTR_SRC_PLL],
    fll_byp_w ? path_src_w[0] : src_s_q[`CTR_SRC_CCO]};

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      path_q <= 5'h00;
    else
      path_q <= path_d;
  end

  // ========================================================================
  // Frequency-locked loop
  // ========================================================================
  ctr_fll_state_t fll_st_q;
  logic ref_prev_q;
  logic [15:0] cco_cnt_q;
  logic [7:0] ref_cnt_q;
  wire ref_rise = path_src_w[0] & ~ref_prev_q;
  wire cco_rise = src_s_q[`CTR_SRC_CCO] & ~src_p_q[`CTR_SRC_CCO];
  wire [15:0] mult_w = fll0_q[15:0];
  wire [7:0] tol_w = fll0_q[23:16];
  wire [7:0] settle_w = fll0_q[31:24];
  wire [7:0] ref_div_w = fll1_q[7:0];
  wire [16:0] err_w = {1'b0, cco_cnt_q} - {1'b0, mult_w};
  wire fast_w = ~err_w[16] & (err_w != 17'h00000);
  wire [16:0] abs_w = err_w[16] ? (17'h00000 - err_w) : err_w;
  wire win_end_w = ref_rise && ({1'b0, ref_cnt_q} + 9'h001 >= {1'b0, ref_div_w});

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      fll_st_q <= CTR_FLL_IDLE;
      ref_prev_q <= 1'b0;
      cco_cnt_q <= 16'h0000;
      ref_cnt_q <= 8'h00;
      fll_lock_q <= 1'b0;
      controlled_osc_freq_q <= `CTR_FREQ_RST;
    end
    else
    begin
      ref_prev_q <= path_src_w[0];
      case (fll_st_q)
        CTR_FLL_IDLE:
        begin
          fll_lock_q <= 1'b0;
          cco_cnt_q <= 16'h0000;
          ref_cnt_q <= 8'h00;
          if (!fll_byp_w && ref_rise)
            fll_st_q <= CTR_FLL_MEAS;
        end
        CTR_FLL_MEAS:
        begin
          if (fll_byp_w)
            fll_st_q <= CTR_FLL_IDLE;
          else if (win_end_w)
          begin
            fll_lock_q <= (abs_w <= {9'h000, tol_w});
            if (fast_w && controlled_osc_freq_q != 9'h000)
              controlled_osc_freq_q <= controlled_osc_freq_q - 9'h001;
            else if (err_w[16] && controlled_osc_freq_q != 9'h1ff)
              controlled_osc_freq_q <= controlled_osc_freq_q + 9'h001;
            ref_cnt_q <= 8'h00;
            fll_st_q <= CTR_FLL_SETTLE;
          end
          else
          begin
            if (cco_rise)
              cco_cnt_q <= cco_cnt_q + 16'h0001;
            if (ref_rise)
              ref_cnt_q <= ref_cnt_q + 8'h01;
          end
        end
        CTR_FLL_SETTLE:
        begin
          cco_cnt_q <= 16'h0000;
          if (fll_byp_w)
            fll_st_q <= CTR_FLL_IDLE;
          else if (ref_cnt_q >= settle_w)
          begin
            ref_cnt_q <= 8'h00;
            fll_st_q <= CTR_FLL_MEAS;
          end
          else if (ref_rise)
            ref_cnt_q <= ref_cnt_q + 8'h01;
        end
        default:
          fll_st_q <= CTR_FLL_IDLE;
      endcase
    end
  end

  // ========================================================================
  // High-frequency roots
  // ========================================================================
  for (genvar r = 0; r < 5; r++)
  begin : g_root
    wire [3:0] rsel_w = root_q[r][3:0];
    wire [1:0] pdiv_w = root_q[r][5:4];
    wire en_w = (r == 0) ? 1'b1 : root_q[r][31];
    wire rsrc_w = (rsel_w <= 4'h4) ? path_q[3'(rsel_w)] : 1'b0;
    wire [7:0] rdiv_w = (8'h01 << pdiv_w) - 8'h01;

    always_ff @(posedge clk_sys)
    begin
      if (!resetn)
        root_q[r] <= 32'h0000_0000;
      else if (wr_w && root_hit_w && root_idx_w == 3'(r))
        root_q[r] <= {apb_req.pwdata[31], 25'h0000000, apb_req.pwdata[5:0]};
    end

    ctr_div u_root_div (.clk_sys(clk_sys), .resetn(resetn), .src(rsrc_w), .div(rdiv_w),
      .en(en_w), .out_q(high_freq_root_clock[r]));
  end

  // Same flops feed the interconnect, predivider included
  assign interconnect_root_clock = high_freq_root_clock;

  // ========================================================================
  // Low-frequency, pump and timer clocks
  // ========================================================================
  wire [1:0] lf_sel_w = misc_q[`CTR_MISC_LF];
  wire lf_d = (lf_sel_w == 2'h0) ? src_s_q[`CTR_SRC_ILO] :
    (lf_sel_w == 2'h1) ? src_s_q[`CTR_SRC_PRECISION_LOW_OSC] :
    (lf_sel_w == 2'h2) ? src_s_q[`CTR_SRC_WCO] : 1'b0;

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
      low_freq_clock_q <= 1'b0;
    else
      low_freq_clock_q <= lf_d;
  end

  wire [2:0] pump_path_w = misc_q[`CTR_MISC_PUMP_PATH];
  wire [2:0] pump_code_w = misc_q[`CTR_MISC_PUMP_DIV];
  wire pump_path_clk_w = (pump_path_w <= 3'h4) ? path_q[pump_path_w] : 1'b0;
  wire pump_src_w = misc_q[`CTR_MISC_PUMP_ALT] ? src_s_q[`CTR_SRC_PUMP_ALT] : pump_path_clk_w;
  wire [7:0] pump_div_w = (pump_code_w <= 3'h4) ? ((8'h01 << pump_code_w) - 8'h01) : 8'h00;

  ctr_div u_pump_div (.clk_sys(clk_sys), .resetn(resetn), .src(pump_src_w), .div(pump_div_w),
    .en(misc_q[`CTR_MISC_PUMP_EN]), .out_q(pump_clock_q));

  wire timer_src_w = misc_q[`CTR_MISC_TIMER_SEL] ? high_freq_root_clock[0]
    : src_s_q[`CTR_SRC_IMO];
  wire [7:0] timer_div_w = (8'h01 << misc_q[`CTR_MISC_TIMER_DIV]) - 8'h01;

  ctr_div u_timer_div (.clk_sys(clk_sys), .resetn(resetn), .src(timer_src_w),
    .div(timer_div_w), .en(1'b1), .out_q(timer_clock_q));

  // ========================================================================
  // Clocks derived from root 0
  // ========================================================================
  ctr_div u_core_div (.clk_sys(clk_sys), .resetn(resetn), .src(high_freq_root_clock[0]),
    .div(div_q[7:0]), .en(1'b1), .out_q(core_clock_q));

  ctr_div u_peri_div (.clk_sys(clk_sys), .resetn(resetn), .src(high_freq_root_clock[0]),
    .div(div_q[15:8]), .en(1'b1), .out_q(peripheral_source_clock_q));

  ctr_div u_aux_div (.clk_sys(clk_sys), .resetn(resetn), .src(peripheral_source_clock_q),
    .div(div_q[23:16]), .en(1'b1), .out_q(aux_core_clock_q));

  ctr_div u_group_div (.clk_sys(clk_sys), .resetn(resetn), .src(high_freq_root_clock[0]),
    .div(div_q[31:24]), .en(1'b1), .out_q(group_clock_q));

  // ========================================================================
  // Status
  // ========================================================================
  assign status_w = {12'h000, high_freq_root_clock, fll_st_q, 1'b0,
    controlled_osc_freq_q, 2'b00, fll_lock_q};

endmodule // ctr_clock_tree
`default_nettype wire

/* File: core/ctr_clock_tree_cfg.svh */
/*
  Register map, field positions, reset values and source indices of the clock tree.
  Assumes inclusion by its bare name from the clock tree design file.
*/
// Behaviour
// - Five paths: FREQUENCY_LOCKED_LOOP, PLL, three direct
// - FREQUENCY_LOCKED_LOOP and PLL can be bypassed
// - Path source 3-bit code, 5-7 reserved
// - Interconnect mux: 0,1,16,17,19 valid
// - Five high-frequency roots with fixed destinations
// - Every root also feeds the interconnect
// - Root selector codes 0-4 pick paths
// - Root predivider 1,2,4,8 by 2-bit code
// - Roots 1-4 gateable, root 0 always on
// - Low-frequency clock selects three low oscillators
// - Pump clock: path or alternate pump clock, /1-/16, gateable
// - Group clock from 8-bit divider, default /1
// - Tick timer clock: main osc or root 0
// - Core clock divides root 0
// - Peripheral source clock divides root 0
// - Auxiliary core clock divides peripheral source
// - FREQUENCY_LOCKED_LOOP unlocks when error exceeds tolerance
// - FREQUENCY_LOCKED_LOOP step is measurement plus settling
// - FREQUENCY_LOCKED_LOOP counts osc cycles per reference window
// - FREQUENCY_LOCKED_LOOP waits settling reference clocks after change
`ifndef CTR_CLOCK_TREE_CFG_SVH
`define CTR_CLOCK_TREE_CFG_SVH
// Byte offsets
`define CTR_OFS_PATH_SEL 12'h000
`define CTR_OFS_IC_SEL 12'h004
`define CTR_OFS_MISC 12'h008
`define CTR_OFS_DIV 12'h00c
`define CTR_OFS_ROOT0 12'h010
`define CTR_OFS_FLL0 12'h024
`define CTR_OFS_FLL1 12'h028
`define CTR_OFS_STATUS 12'h02c
// Field positions in the misc register
`define CTR_MISC_LF 1:0
`define CTR_MISC_PUMP_PATH 4:2
`define CTR_MISC_PUMP_DIV 7:5
`define CTR_MISC_PUMP_EN 8
`define CTR_MISC_PUMP_ALT 9
`define CTR_MISC_TIMER_SEL 10
`define CTR_MISC_TIMER_DIV 12:11
`define CTR_MISC_FLL_BYP 13
`define CTR_MISC_PLL_BYP 14
// Reset values
`define CTR_MISC_RST 32'h0000_6000
`define CTR_FLL0_RST 32'h0801_0010
`define CTR_FLL1_RST 32'h0000_0001
`define CTR_FREQ_RST 9'h100
// Source indices in the synchronised input vector
`define CTR_SRC_IMO 0
`define CTR_SRC_ILO 4
`define CTR_SRC_WCO 5
`define CTR_SRC_PRECISION_LOW_OSC 6
`define CTR_SRC_IC0 7
`define CTR_SRC_CCO 9
`define CTR_SRC_PLL 10
`define CTR_SRC_PUMP_ALT 11
`define CTR_NSRC 12
`endif

/* File: core/ctr_pkg.sv */
/*
  Types of the clock tree: bus carriers and the FREQUENCY_LOCKED_LOOP state.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package ctr_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ctr_apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ctr_apb_rsp_t;
  typedef enum logic [1:0] {CTR_FLL_IDLE, CTR_FLL_MEAS, CTR_FLL_SETTLE} ctr_fll_state_t;
endpackage

/* File: bench/ctr_clock_tree_asserts.sv */
/*
  Checker of bus timing and root clock relations of the clock tree.
  Assumes it is bound to ctr_clock_tree and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// Checker
module ctr_clock_tree_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register bus
  input wire ctr_pkg::ctr_apb_req_t apb_req,
  input wire ctr_pkg::ctr_apb_rsp_t apb_rsp_q,
  // Loop and roots
  input wire logic [8:0] controlled_osc_freq_q,
  input wire logic fll_lock_q,
  input wire logic [4:0] high_freq_root_clock,
  input wire logic [4:0] interconnect_root_clock
);
  import ctr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  sequence setup_s;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence answer_s;
    apb_rsp_q.pready ##1 !apb_rsp_q.pready;
  endsequence
  AST_ANSWER: assert property (setup_s |=> answer_s)
    else $error("no single ready pulse after setup");
  AST_READY_CAUSE: assert property (apb_rsp_q.pready |->
    apb_req.psel && apb_req.penable && $past(apb_req.psel && !apb_req.penable))
    else $error("ready outside access phase");
  AST_IDLE_DATA: assert property (!apb_rsp_q.pready |->
    apb_rsp_q.prdata == 32'h0 && !apb_rsp_q.pslverr)
    else $error("response fields set without ready");
  AST_ERR_ADDR: assert property (apb_rsp_q.pready |-> apb_rsp_q.pslverr ==
    (apb_req.paddr[1:0] != 2'h0 || apb_req.paddr > 12'h02c))
    else $error("error flag does not match address");
  AST_ERR_DATA: assert property (apb_rsp_q.pslverr |-> apb_rsp_q.prdata == 32'h0)
    else $error("data returned with error");
  AST_IC_COPY: assert property (interconnect_root_clock == high_freq_root_clock)
    else $error("interconnect copy differs from root");
  AST_FREQ_STEP: assert property ($changed(controlled_osc_freq_q) |->
    controlled_osc_freq_q - $past(controlled_osc_freq_q) == 9'h001 ||
    $past(controlled_osc_freq_q) - controlled_osc_freq_q == 9'h001)
    else $error("frequency code moved by more than one");
  AST_FREQ_RST: assert property ($rose(resetn) |-> controlled_osc_freq_q == 9'h100 &&
    !fll_lock_q && high_freq_root_clock == 5'h00)
    else $error("wrong state after reset");
endmodule // ctr_clock_tree_asserts

bind ctr_clock_tree ctr_clock_tree_asserts u_chk (
  .clk_sys(clk_sys),
  .resetn(resetn),
  .apb_req(apb_req),
  .apb_rsp_q(apb_rsp_q),
  .controlled_osc_freq_q(controlled_osc_freq_q),
  .fll_lock_q(fll_lock_q),
  .high_freq_root_clock(high_freq_root_clock),
  .interconnect_root_clock(interconnect_root_clock)
);
`default_nettype wire

/* File: bench/ctr_osc_model.sv */
/*
  Oscillator model: free-running levels, or levels held by the bench.
  Assumes clk_sys is far faster; every phase lasts at least 2 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// Oscillators
module ctr_osc_model (
  // Clock
  input wire logic clk_sys,
  // Control
  input wire logic run,
  input wire logic [11:0] lvl,
  // Levels in source order
  output logic [11:0] osc
);
  logic [11:0] ph_q = 12'h000;
  logic [3:0] cnt_q [12] = '{default: 4'h0};
  // Loop oscillator runs faster than the reference
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 12; i++)
    begin
      cnt_q[i] <= (cnt_q[i] >= ((i == 9) ? 4'h2 : 4'h3)) ? 4'h1 : cnt_q[i] + 4'h1;
      if (cnt_q[i] >= ((i == 9) ? 4'h2 : 4'h3))
        ph_q[i] <= !ph_q[i];
    end
  end
  assign osc = run ? ph_q : lvl;
endmodule // ctr_osc_model
`default_nettype wire

/* File: bench/test_ctr_clock_tree.sv */
/*
  Testbench of the clock tree: register tasks, source selection, dividers, loop.
  Assumes the design, checker and oscillator model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
// ====================
// Bench
module test_ctr_clock_tree;
  import ctr_pkg::*;
  logic clk_sys, resetn, run, err, lock;
  logic [11:0] lvl, osc, mons, prev;
  logic [31:0] rd;
  logic [8:0] freq;
  logic [4:0] hf, ichf;
  wire [6:0] dc;
  ctr_apb_req_t req;
  ctr_apb_rsp_t rsp;
  int n_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int edges [12];
  logic [11:0] ofs [7] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h024, 12'h028};
  logic [31:0] rst [7] = '{0, 0, 32'h00006000, 0, 0, 32'h08010010, 32'h00000001};
  int icc [8] = '{0, 1, 16, 17, 19, 2, 18, 31};
  int ics [8] = '{7, 8, 4, 5, 6, 12, 12, 12};
  logic [15:0] mv [9] = '{16'h6000, 16'h6001, 16'h6002, 16'h6003, 16'h6000, 16'h6400,
    16'h600c, 16'h610c, 16'h630c};
  int ms [9] = '{4, 6, 5, 12, 0, 1, 3, 3, 11};
  int mi [9] = '{5, 5, 5, 5, 7, 7, 6, 6, 6};
  logic me [9] = '{1, 1, 1, 0, 1, 1, 0, 1, 1};
  assign mons = {dc, hf};
  ctr_osc_model u_osc (.clk_sys(clk_sys), .run(run), .lvl(lvl), .osc(osc));
  ctr_clock_tree DUT (
    .clk_sys(clk_sys), .resetn(resetn), .apb_req(req), .apb_rsp_q(rsp),
    .internal_main_osc(osc[0]), .external_clock_in(osc[1]), .external_crystal_osc(osc[2]),
    .alternate_high_freq_source(osc[3]), .internal_low_osc(osc[4]),
    .watch_crystal_osc(osc[5]), .precision_low_osc(osc[6]), .interconnect_out(osc[8:7]),
    .controlled_osc(osc[9]), .pll_clk(osc[10]), .pump_alt_clk(osc[11]),
    .controlled_osc_freq_q(freq), .fll_lock_q(lock), .high_freq_root_clock(hf),
    .interconnect_root_clock(ichf), .low_freq_clock_q(dc[0]), .pump_clock_q(dc[1]),
    .timer_clock_q(dc[2]), .core_clock_q(dc[3]), .peripheral_source_clock_q(dc[4]),
    .aux_core_clock_q(dc[5]), .group_clock_q(dc[6])
  );
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    for (int i = 0; i < 12; i++)
      if (mons[i] === 1'b1 && prev[i] === 1'b0)
        edges[i]++;
    prev <= mons;
  end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end
  // ====================
  // Tasks
  task automatic conclude();
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic near(input int got, input int exp);
    chk({31'h0, got >= exp - 1 && got <= exp + 1}, 32'h1);
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    // Ends when ready is seen; only the bench timeout ends a wait that never sees it
    do
      @(posedge clk_sys);
    while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask
  function automatic logic [11:0] msk(input int s);
    return (s < 12) ? 12'h1 << s : 12'hfff;
  endfunction
  // Selected source high then low; output must follow, or stay low
  task automatic pick(input int s, input logic [11:0] m, input logic e);
    lvl <= m;
    repeat (10) @(posedge clk_sys);
    chk({31'h0, mons[s]}, {31'h0, e});
    lvl <= ~m;
    repeat (10) @(posedge clk_sys);
    chk({31'h0, mons[s]}, 32'h0);
  endtask
  task automatic pulses(input int b);
    edges = '{default: 0};
    repeat (32)
    begin
      lvl[b] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lvl[b] <= 1'b0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (10) @(posedge clk_sys);
  endtask
  task automatic window();
    edges = '{default: 0};
    repeat (240) @(posedge clk_sys);
  endtask
  // ====================
  // Sequence
  initial
  begin
    resetn = 1'b0;
    run = 1'b0;
    lvl = 12'h000;
    req = '0;
    prev = 12'h000;
    edges = '{default: 0};
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    foreach (ofs[i])
    begin
      apb(1'b0, ofs[i], 32'h0);
      chk(rd, rst[i]);
    end
    apb(1'b0, 12'h030, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h009, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h02c, 32'hffffffff);
    chk({31'h0, err}, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h00006000);
    apb(1'b1, 12'h000, 32'h100);
    apb(1'b1, 12'h010, 32'h2);
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b1, 12'h004, 32'(icc[i]) << 10);
      pick(0, msk(ics[i]), ics[i] < 12);
    end
    // Path 2 interconnect mux back to its first output for the code 4 case
    apb(1'b1, 12'h004, 32'h0);
    for (int p = 0; p < 2; p++)
      for (int c = 0; c < 8; c++)
      begin
        if (p == 0)
          apb(1'b1, 12'h000, 32'(c) << 6);
        else
        begin
          apb(1'b1, 12'h000, 32'h4688);
          apb(1'b1, 12'h010, 32'(c));
        end
        pick(0, (c == 4) ? 12'h080 : msk((c < 4) ? c : 12), c < 5);
      end
    apb(1'b1, 12'h010, 32'h1);
    for (int en = 0; en < 2; en++)
    begin
      apb(1'b1, 12'h014, 32'(en) << 31);
      pick(1, 12'h001, en == 1);
    end
    foreach (mv[i])
    begin
      apb(1'b1, 12'h008, {16'h0, mv[i]});
      pick(mi[i], msk(ms[i]), me[i]);
    end
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, 12'h010, 32'h1 | (32'(k) << 4));
      pulses(1);
      near(edges[0], 32 >> k);
    end
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h00c, 32'h00010301);
    pulses(1);
    near(edges[8], 16);
    near(edges[9], 8);
    near(edges[10], 4);
    near(edges[11], 32);
    run <= 1'b1;
    apb(1'b1, 12'h008, 32'h6000);
    apb(1'b1, 12'h010, 32'h0);
    apb(1'b1, 12'h024, 32'h0202000c);
    apb(1'b1, 12'h028, 32'h108);
    window();
    near(edges[0], 40);
    apb(1'b1, 12'h008, 32'h4000);
    for (int t = 0; t < 2000 && lock !== 1'b1; t++)
      @(posedge clk_sys);
    chk({31'h0, lock}, 32'h1);
    window();
    near(edges[0], 60);
    apb(1'b1, 12'h024, 32'h02000064);
    repeat (1000) @(posedge clk_sys);
    chk({31'h0, lock}, 32'h0);
    chk({31'h0, freq > 9'h100}, 32'h1);
    conclude();
  end
endmodule // test_ctr_clock_tree
`default_nettype wire
